// File: acfg_pkg.sv
package acfg_pkg;

    // ------------------------------------------------------------
    // Register addresses (15-bit SPI address space)
    // ------------------------------------------------------------
    localparam logic [14:0] ADDR_IFACE = 15'h000;
    localparam logic [14:0] ADDR_PWR = 15'h002;
    localparam logic [14:0] ADDR_CLASS = 15'h003;
    localparam logic [14:0] ADDR_PART_LO = 15'h004;
    localparam logic [14:0] ADDR_PART_HI = 15'h005;
    localparam logic [14:0] ADDR_MAKER_LO = 15'h00c;
    localparam logic [14:0] ADDR_MAKER_HI = 15'h00d;
    localparam logic [14:0] ADDR_USER = 15'h010;
    localparam logic [14:0] ADDR_OFS_LO = 15'h34e;
    localparam logic [14:0] ADDR_OFS_HI = 15'h34f;
    localparam logic [14:0] ADDR_GAIN0 = 15'h360;
    localparam logic [14:0] ADDR_GAIN1 = 15'h361;
    localparam logic [14:0] ADDR_GAIN4 = 15'h364;
    localparam logic [14:0] ADDR_GAIN5 = 15'h365;

    // ------------------------------------------------------------
    // Fuse-loaded trim bytes, in instance order
    // ------------------------------------------------------------
    localparam int N_TRIM = 6;
    localparam logic [14:0] TRIM_ADDR [N_TRIM] = '{
        ADDR_GAIN0, ADDR_GAIN1, ADDR_GAIN4, ADDR_GAIN5, ADDR_OFS_LO, ADDR_OFS_HI
    };

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_SOFT_BIT = 7;
    localparam int CFG_ASC_BIT = 5;
    localparam int CFG_SOUT_BIT = 4;
    localparam int USR_HOLD_BIT = 0;
    localparam int HDR_RW_BIT = 15;
    localparam logic [7:0] IFACE_RST = 8'h30;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] USER_RST = 8'h00;
    localparam logic [3:0] CLASS_RES_RST = 4'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PD = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SOFT_RST_NS = 750;
    // Longest time, so rounded down
    localparam int SOFT_RST_CYC = SOFT_RST_NS / CLK_PERIOD_NS;

    // Serial engine states
    typedef enum logic [2:0] {
        ST_WAIT, ST_BUSY, ST_IDLE, ST_HDR, ST_DATA
    } acfg_state_t;

endpackage : acfg_pkg

// File: acfg_trim_byte.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// One fuse-initialised trim byte at a fixed address
// ------------------------------------------------------------
module acfg_trim_byte
    import acfg_pkg::*;
#(
    parameter logic [14:0] ADDR = 15'h000 // Address of this byte
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [7:0] fuse_val,
    input wire logic wr_en,
    input wire logic [14:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);

    // Fuse copy wins over a write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value <= 8'h00;
        end else if (load) begin
            value <= fuse_val;
        end else if (wr_en && wr_addr == ADDR) begin
            value <= wr_data;
        end
    end

endmodule : acfg_trim_byte

// File: acfg_spi_regs.sv
`timescale 1ns/1ps
module acfg_spi_regs
    import acfg_pkg::*;
#(
    parameter logic [3:0] PART_CLASS_CODE = 4'ha, // Value arbitrary
    parameter logic [15:0] PART_ID_CODE = 16'h5a3c, // Value arbitrary
    parameter logic [15:0] MAKER_CODE = 16'h1d2e // Value arbitrary
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic [7:0] fuse_fine_gain_bank_zero,
    input wire logic [7:0] fuse_fine_gain_bank_one,
    input wire logic [7:0] fuse_fine_gain_bank_four,
    input wire logic [7:0] fuse_fine_gain_bank_five,
    input wire logic [15:0] fuse_offset_trim,
    output logic [7:0] fine_gain_bank_zero,
    output logic [7:0] fine_gain_bank_one,
    output logic [7:0] fine_gain_bank_four,
    output logic [7:0] fine_gain_bank_five,
    output logic [15:0] offset_trim_second_conv_second_input,
    output logic power_down,
    output logic soft_reset_busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic rst_meta_reg; // First synchroniser stage
    logic rst_n_reg; // Released reset used everywhere
    logic sclk_d_reg; // Previous serial clock level
    acfg_state_t state_reg; // Serial engine state
    logic [3:0] bit_cnt_reg; // Bit counter within header or byte
    logic [15:0] hdr_reg; // Header shift register
    logic [7:0] rx_reg; // Data byte shift register
    logic [7:0] tx_reg; // Read data shift register
    logic sdo_reg; // Serial output bit
    logic rw_reg; // One for a read access
    logic [14:0] addr_reg; // Current register address
    logic busy_reg; // Soft reset still settling
    logic [6:0] busy_cnt_reg; // Settling countdown
    logic soft_rst_reg; // One-cycle soft reset pulse
    logic fuse_load_reg; // Copy fuse values this cycle
    logic [7:0] iface_reg; // Interface config
    logic [7:0] pwr_reg; // Power config
    logic [3:0] class_res_reg; // Writable upper class bits
    logic [7:0] user_reg; // User serial config
    logic pd_reg; // Power-down decoded
    logic sclk_rise; // Serial clock rising edge
    logic sclk_fall; // Serial clock falling edge
    logic hdr_done; // Last header bit taken
    logic byte_done; // Last bit of a data byte taken
    logic wr_en; // Write strobe for addr_reg
    logic [15:0] hdr_shift; // Header including this bit
    logic [7:0] rx_shift; // Data byte including this bit
    logic [14:0] addr_step; // Address of the next byte
    logic [14:0] rd_addr; // Address whose data loads tx_reg
    logic [7:0] rd_byte; // Read mux output
    logic [7:0] fuse_arr [N_TRIM]; // Fuse values per trim byte
    logic [7:0] trim_q [N_TRIM]; // Trim byte contents

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------

    // Assert at once, release two edges later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Serial pin decode
    // ------------------------------------------------------------

    // Pins are synchronous, so one delay gives both edges
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= spi_sclk;
        end
    end

    // Edge strobes and shift previews
    always_comb begin
        sclk_rise = spi_sclk & ~sclk_d_reg;
        sclk_fall = ~spi_sclk & sclk_d_reg;
        hdr_shift = {hdr_reg[14:0], spi_sdi};
        rx_shift = {rx_reg[6:0], spi_sdi};
        hdr_done = (state_reg == ST_HDR) && sclk_rise && (bit_cnt_reg == 4'hf);
        byte_done = (state_reg == ST_DATA) && sclk_rise && (bit_cnt_reg[2:0] == 3'h7);
        wr_en = byte_done && !rw_reg;
    end

    // Next address: hold, else step by the ascend bit
    always_comb begin
        if (user_reg[USR_HOLD_BIT]) begin
            addr_step = addr_reg;
        end else if (iface_reg[CFG_ASC_BIT]) begin
            addr_step = addr_reg + 15'h1;
        end else begin
            addr_step = addr_reg - 15'h1;
        end
        rd_addr = hdr_done ? hdr_shift[14:0] : addr_step;
    end

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------

    // Frame sequencing; soft reset parks the engine while settling
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_WAIT;
        end else if (soft_rst_reg) begin
            state_reg <= ST_BUSY;
        end else begin
            case (state_reg)
                // Ignore the pins until settled
                ST_BUSY: begin
                    if (!busy_reg) begin
                        state_reg <= ST_WAIT;
                    end
                end
                // A frame must start cleanly with select high
                ST_WAIT: begin
                    if (spi_cs_n) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!spi_cs_n) begin
                        state_reg <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (spi_cs_n) begin
                        state_reg <= ST_IDLE;
                    end else if (hdr_done) begin
                        state_reg <= ST_DATA;
                    end
                end
                // Streaming goes on until select rises
                ST_DATA: begin
                    if (spi_cs_n) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_WAIT;
                end
            endcase
        end
    end

    // Bit counter wraps from header into byte counting
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            bit_cnt_reg <= 4'h0;
        end else if ((state_reg != ST_HDR && state_reg != ST_DATA) || spi_cs_n) begin
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Input shift registers sample sdi on rising edges
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hdr_reg <= 16'h0000;
            rx_reg <= 8'h00;
        end else if (sclk_rise) begin
            if (state_reg == ST_HDR) begin
                hdr_reg <= hdr_shift;
            end
            if (state_reg == ST_DATA) begin
                rx_reg <= rx_shift;
            end
        end
    end

    // Direction and address; address steps after each byte unless the hold bit is set
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rw_reg <= 1'b0;
            addr_reg <= 15'h0000;
        end else if (soft_rst_reg) begin
            rw_reg <= 1'b0;
            addr_reg <= 15'h0000;
        end else if (hdr_done) begin
            rw_reg <= hdr_shift[HDR_RW_BIT];
            addr_reg <= hdr_shift[14:0];
        end else if (byte_done) begin
            addr_reg <= addr_step;
        end
    end

    // Read data leaves on sdo, changing on falling edges
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_reg <= 8'h00;
            sdo_reg <= 1'b0;
        end else if (state_reg != ST_HDR && state_reg != ST_DATA) begin
            tx_reg <= 8'h00;
            sdo_reg <= 1'b0;
        end else if (hdr_done || byte_done) begin
            tx_reg <= rd_byte;
        end else if (sclk_fall && state_reg == ST_DATA) begin
            sdo_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------

    // Unmapped addresses read as zero
    always_comb begin
        rd_byte = 8'h00;
        case (rd_addr)
            ADDR_IFACE: rd_byte = iface_reg;
            ADDR_PWR: rd_byte = pwr_reg;
            ADDR_CLASS: rd_byte = {class_res_reg, PART_CLASS_CODE};
            ADDR_PART_LO: rd_byte = PART_ID_CODE[7:0];
            ADDR_PART_HI: rd_byte = PART_ID_CODE[15:8];
            ADDR_MAKER_LO: rd_byte = MAKER_CODE[7:0];
            ADDR_MAKER_HI: rd_byte = MAKER_CODE[15:8];
            ADDR_USER: rd_byte = user_reg;
            default: rd_byte = 8'h00;
        endcase
        for (int i = 0; i < N_TRIM; i++) begin
            if (rd_addr == TRIM_ADDR[i]) begin
                rd_byte = trim_q[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Soft reset
    // ------------------------------------------------------------

    // The reset bit is never stored, so it reads back as zero
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_en && addr_reg == ADDR_IFACE && rx_shift[CFG_SOFT_BIT];
        end
    end

    // Fuse copy after hard reset and after every soft reset
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fuse_load_reg <= 1'b1;
        end else begin
            fuse_load_reg <= soft_rst_reg;
        end
    end

    // Settling window; the host keeps off the bus meanwhile
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= 7'h00;
        end else if (soft_rst_reg) begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= 7'(SOFT_RST_CYC - 1);
        end else if (busy_reg) begin
            if (busy_cnt_reg == 7'h00) begin
                busy_reg <= 1'b0;
            end else begin
                busy_cnt_reg <= busy_cnt_reg - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // Indicator bit forced to one on every write
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            iface_reg <= IFACE_RST;
        end else if (soft_rst_reg) begin
            iface_reg <= IFACE_RST;
        end else if (wr_en && addr_reg == ADDR_IFACE) begin
            iface_reg <= {1'b0, rx_shift[6:5], 1'b1, rx_shift[3:0]};
        end
    end

    // Power config; reserved mode codes are stored but act as normal
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pwr_reg <= PWR_RST;
            pd_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            pwr_reg <= PWR_RST;
            pd_reg <= 1'b0;
        end else begin
            if (wr_en && addr_reg == ADDR_PWR) begin
                pwr_reg <= rx_shift;
            end
            pd_reg <= (pwr_reg[1:0] == MODE_PD);
        end
    end

    // Upper class bits writable, lower bits fixed
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            class_res_reg <= CLASS_RES_RST;
        end else if (soft_rst_reg) begin
            class_res_reg <= CLASS_RES_RST;
        end else if (wr_en && addr_reg == ADDR_CLASS) begin
            class_res_reg <= rx_shift[7:4];
        end
    end

    // User serial config with the address-hold bit
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            user_reg <= USER_RST;
        end else if (soft_rst_reg) begin
            user_reg <= USER_RST;
        end else if (wr_en && addr_reg == ADDR_USER) begin
            user_reg <= rx_shift;
        end
    end

    // ------------------------------------------------------------
    // Trim bytes
    // ------------------------------------------------------------

    // Fuse inputs in the package instance order
    always_comb begin
        fuse_arr[0] = fuse_fine_gain_bank_zero;
        fuse_arr[1] = fuse_fine_gain_bank_one;
        fuse_arr[2] = fuse_fine_gain_bank_four;
        fuse_arr[3] = fuse_fine_gain_bank_five;
        fuse_arr[4] = fuse_offset_trim[7:0];
        fuse_arr[5] = fuse_offset_trim[15:8];
    end

    // Offset trim is two bytes, low byte at the lower address
    for (genvar g = 0; g < N_TRIM; g++) begin : g_trim
        acfg_trim_byte #(
            .ADDR(TRIM_ADDR[g])
        ) u_trim (
            .clk_sys(clk_sys),
            .rst_n(rst_n_reg),
            .load(fuse_load_reg),
            .fuse_val(fuse_arr[g]),
            .wr_en(wr_en),
            .wr_addr(addr_reg),
            .wr_data(rx_shift),
            .value(trim_q[g])
        );
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign spi_sdo = sdo_reg;
    assign power_down = pd_reg;
    assign soft_reset_busy = busy_reg;
    assign fine_gain_bank_zero = trim_q[0];
    assign fine_gain_bank_one = trim_q[1];
    assign fine_gain_bank_four = trim_q[2];
    assign fine_gain_bank_five = trim_q[3];
    assign offset_trim_second_conv_second_input = {trim_q[5], trim_q[4]};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_reg);

    property p_soft_clear;
        (wr_en && addr_reg == ADDR_IFACE && rx_shift[CFG_SOFT_BIT]) |=>
            soft_rst_reg ##1 (busy_reg && !iface_reg[CFG_SOFT_BIT] && pwr_reg == PWR_RST);
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset failed");

    property p_settle;
        soft_rst_reg |-> ##93 busy_reg ##1 !busy_reg;
    endproperty
    a_settle: assert property (p_settle) else $error("settle length wrong");

    property p_inc;
        (byte_done && !user_reg[USR_HOLD_BIT] && iface_reg[CFG_ASC_BIT])
            |=> addr_reg == $past(addr_reg) + 15'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("no increment");

    property p_dec;
        (byte_done && !user_reg[USR_HOLD_BIT] && !iface_reg[CFG_ASC_BIT])
            |=> addr_reg == $past(addr_reg) - 15'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement");

    property p_hold;
        (byte_done && user_reg[USR_HOLD_BIT]) |=> $stable(addr_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("address moved");

    property p_sout;
        (hdr_done && hdr_shift[14:0] == ADDR_IFACE) |=> tx_reg[CFG_SOUT_BIT];
    endproperty
    a_sout: assert property (p_sout) else $error("indicator not one");

    property p_pd;
        (wr_en && addr_reg == ADDR_PWR && rx_shift[1:0] == MODE_PD) |-> ##2 power_down;
    endproperty
    a_pd: assert property (p_pd) else $error("no power-down");

    property p_class;
        (hdr_done && hdr_shift[14:0] == ADDR_CLASS) |=> tx_reg[3:0] == PART_CLASS_CODE;
    endproperty
    a_class: assert property (p_class) else $error("class code wrong");

    property p_part;
        (hdr_done && hdr_shift[14:0] == ADDR_PART_HI) |=> tx_reg == PART_ID_CODE[15:8];
    endproperty
    a_part: assert property (p_part) else $error("part code wrong");

    property p_maker;
        (hdr_done && hdr_shift[14:0] == ADDR_MAKER_LO) |=> tx_reg == MAKER_CODE[7:0];
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_user_rst;
        soft_rst_reg |=> user_reg == USER_RST && iface_reg == IFACE_RST;
    endproperty
    a_user_rst: assert property (p_user_rst) else $error("reset value wrong");

    property p_fuse;
        fuse_load_reg |=> fine_gain_bank_five == $past(fuse_fine_gain_bank_five)
            && offset_trim_second_conv_second_input == $past(fuse_offset_trim);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse copy missing");

    c_soft: cover property (soft_rst_reg);
    c_read_id: cover property (hdr_done && hdr_shift[HDR_RW_BIT] && hdr_shift[14:0] == ADDR_PART_LO);
    c_stream: cover property (byte_done ##[1:300] byte_done);
    c_pd: cover property ($rose(power_down));

endmodule : acfg_spi_regs

// File: acfg_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// SPI host: mode 0, MSB first, six cycles per half bit
// ------------------------------------------------------------
module acfg_host_model (
    input wire logic clk_sys,
    input wire logic spi_sdo,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_sdi
);
    logic [7:0] rx_q [$]; // Bytes seen on sdo
    // Idle: deselected, clock parked low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end
    // Slow half periods leave room for the sampled clock to be seen
    task automatic bit_x(input logic b, output logic r);
        spi_sclk <= 1'b0;
        spi_sdi <= b;
        repeat (5) @(posedge clk_sys);
        #1 r = spi_sdo;
        @(posedge clk_sys);
        spi_sclk <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : bit_x
    // Header, then n bytes; every byte shifted in is queued
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] wd [4],
        input int n);
        logic [15:0] hdr;
        logic [7:0] rb;
        logic r;
        hdr = {rd, a};
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) bit_x(hdr[i], r);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_x(wd[k][i], r);
                rb[i] = r;
            end
            rx_q.push_back(rb);
        end
        spi_sclk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        spi_cs_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : frame
    // Quiet time after a soft reset, 750 ns rounded up
    task automatic settle();
        repeat (94) @(posedge clk_sys);
    endtask : settle
endmodule : acfg_host_model

// File: tb.sv
`timescale 1ns/1ps
module tb
    import acfg_pkg::*;
();
    // ------------------------------------------------------------
    // Clock, reset and fuse levels
    // ------------------------------------------------------------
    localparam logic [15:0] PID = 16'h5a3c; // Value arbitrary
    localparam logic [15:0] MID = 16'h1d2e; // Value arbitrary
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, power_down, soft_reset_busy;
    logic [7:0] g0 = 8'h11, g1 = 8'h22, g4 = 8'h44, g5 = 8'h55;
    logic [15:0] ofs = 16'h9876;
    logic [7:0] o0, o1, o4, o5;
    logic [15:0] oo;
    int num_errors = 0;
    int cmp_count = 0;
    always #4 clk_sys = ~clk_sys;
    acfg_spi_regs #(.PART_CLASS_CODE(4'ha), .PART_ID_CODE(PID), .MAKER_CODE(MID)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .fuse_fine_gain_bank_zero(g0),
        .fuse_fine_gain_bank_one(g1), .fuse_fine_gain_bank_four(g4),
        .fuse_fine_gain_bank_five(g5), .fuse_offset_trim(ofs), .fine_gain_bank_zero(o0),
        .fine_gain_bank_one(o1), .fine_gain_bank_four(o4), .fine_gain_bank_five(o5),
        .offset_trim_second_conv_second_input(oo), .power_down(power_down),
        .soft_reset_busy(soft_reset_busy));
    acfg_host_model host_u (.clk_sys(clk_sys), .spi_sdo(spi_sdo), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi));
    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic cmpv(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmpv
    // Read n bytes (one or two) and compare each in order
    task automatic rchk(input logic [14:0] a, input int n, input logic [7:0] e0,
        input logic [7:0] e1);
        logic [7:0] w [4];
        w = '{default: 8'h00};
        host_u.frame(1'b1, a, w, n);
        cmpv({8'h00, host_u.rx_q.pop_front()}, {8'h00, e0});
        if (n > 1) cmpv({8'h00, host_u.rx_q.pop_front()}, {8'h00, e1});
    endtask : rchk
    // Write n bytes; whatever sdo carried meanwhile is dropped
    task automatic wr(input logic [14:0] a, input logic [7:0] d0, input logic [7:0] d1,
        input int n);
        logic [7:0] w [4];
        w = '{d0, d1, 8'h00, 8'h00};
        host_u.frame(1'b0, a, w, n);
        host_u.rx_q.delete();
    endtask : wr
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // Guard against a hung run
    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rchk(ADDR_IFACE, 1, IFACE_RST, 8'h00);
        rchk(ADDR_PWR, 1, PWR_RST, 8'h00);
        rchk(ADDR_USER, 1, USER_RST, 8'h00);
        rchk(ADDR_CLASS, 1, {CLASS_RES_RST, 4'ha}, 8'h00);
        rchk(ADDR_GAIN0, 2, g0, g1);
        rchk(ADDR_GAIN4, 2, g4, g5);
        rchk(ADDR_OFS_LO, 2, ofs[7:0], ofs[15:8]);
        wr(ADDR_PART_LO, 8'hff, 8'hff, 2);
        rchk(ADDR_PART_LO, 2, PID[7:0], PID[15:8]);
        wr(ADDR_MAKER_LO, 8'h00, 8'h00, 2);
        rchk(ADDR_MAKER_LO, 2, MID[7:0], MID[15:8]);
        wr(ADDR_PWR, {6'h00, MODE_PD}, 8'h00, 1);
        cmpv({15'h0, power_down}, 16'h0001);
        wr(ADDR_PWR, 8'h02, 8'h00, 1);
        cmpv({15'h0, power_down}, 16'h0000);
        // Descending stream, indicator bit cannot be cleared
        wr(ADDR_IFACE, 8'h00, 8'h00, 1);
        rchk(ADDR_IFACE, 1, 8'h10, 8'h00);
        rchk(ADDR_PART_HI, 2, PID[15:8], PID[7:0]);
        wr(ADDR_IFACE, IFACE_RST, 8'h00, 1);
        wr(ADDR_USER, 8'h01, 8'h00, 1);
        rchk(ADDR_PART_LO, 2, PID[7:0], PID[7:0]);
        wr(ADDR_USER, 8'h00, 8'h00, 1);
        wr(ADDR_GAIN0, 8'ha5, 8'h5a, 2);
        cmpv({o1, o0}, 16'h5aa5);
        wr(ADDR_OFS_LO, 8'h34, 8'h12, 2);
        cmpv(oo, 16'h1234);
        // Soft reset must undo every change above
        wr(ADDR_PWR, {6'h00, MODE_PD}, 8'h00, 1);
        wr(ADDR_IFACE, 8'h80, 8'h00, 1);
        cmpv({15'h0, soft_reset_busy}, 16'h0001);
        host_u.settle();
        cmpv({15'h0, soft_reset_busy}, 16'h0000);
        cmpv({15'h0, power_down}, 16'h0000);
        cmpv({o1, o0}, {g1, g0});
        cmpv({o5, o4}, {g5, g4});
        cmpv(oo, ofs);
        rchk(ADDR_IFACE, 1, IFACE_RST, 8'h00);
        rchk(ADDR_PWR, 1, PWR_RST, 8'h00);
        print_verdict();
    end
endmodule : tb
